// ==== lfm_pkg.sv ====
// Constants and types for the LED driver fault manager
package lfm_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned EN_OFF_MS = 16;
  localparam int unsigned EN_OFF_CYC = EN_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned SUPPLY_LOCKOUT_FILT_US = 50;
  localparam int unsigned SUPPLY_LOCKOUT_FILT_CYC = SUPPLY_LOCKOUT_FILT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned IN_TRIP_NS = 3000;
  localparam int unsigned IN_TRIP_CYC = IN_TRIP_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned PRIMARY_LIM_MV = 210;
  localparam int unsigned SECONDARY_PCT = 40;
  localparam int unsigned INPUT_TRIP_MV = 98;
  localparam int unsigned LED_CH = 6;
  localparam int unsigned STARTUP_MASK_CYC = 64;
  localparam int unsigned SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    LFM_OFF = 3'h0,
    LFM_SHORT_CHK = 3'h1,
    LFM_SOFT = 3'h2,
    LFM_RUN = 3'h3,
    LFM_LATCHED = 3'h4
  } lfm_state_t;
endpackage : lfm_pkg

// ==== lfm_sync.sv ====
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/10ps
module lfm_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import lfm_pkg::*;
  logic [WIDTH-1:0] meta_reg;
  initial
  begin
    if (WIDTH < 1) $error("lfm_sync width must be at least one");
  end
  // First stage feeds only the second
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= '0;
      dout <= '0;
    end
    else
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : lfm_sync

// ==== lfm_timer.sv ====
// Qualified duration counter, restarts when its condition drops
`timescale 1ns/10ps
module lfm_timer #(
  parameter int unsigned COUNT = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Condition and result
  input wire logic cond,
  output logic expired
);
  import lfm_pkg::*;
  localparam int unsigned W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_reg;
  initial
  begin
    if (COUNT < 1) $error("lfm_timer count must be at least one");
  end
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= '0;
    else if (!cond)
      cnt_reg <= '0;
    else if (cnt_reg != W'(COUNT))
      cnt_reg <= cnt_reg + W'(1);
  end
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      expired <= 1'b0;
    else
      expired <= cond && (cnt_reg >= W'(COUNT - 1));
  end
endmodule : lfm_timer

// ==== lfm_fault_manager.sv ====
// Fault supervision for a boost LED driver
`timescale 1ns/10ps
module lfm_fault_manager #(
  parameter int unsigned EN_OFF_COUNT = lfm_pkg::EN_OFF_CYC,
  parameter int unsigned SUPPLY_LOCKOUT_COUNT = lfm_pkg::SUPPLY_LOCKOUT_FILT_CYC,
  parameter int unsigned MASK_COUNT = lfm_pkg::STARTUP_MASK_CYC,
  parameter int unsigned LEDS = lfm_pkg::LED_CH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Controller pin
  input wire logic en_dim_pin,
  // Analog comparator outputs (asynchronous)
  input wire logic supply_above_rising,
  input wire logic supply_below_falling,
  input wire logic primary_switch_limit,
  input wire logic secondary_limit_threshold,
  input wire logic input_trip_threshold,
  input wire logic [LEDS-1:0] led_pin_short,
  // Switching cycle from oscillator
  input wire logic cycle_start,
  // Power stage controls
  output logic boost_gate_en,
  output logic disconnect_gate_en,
  output logic sinks_en,
  output logic soft_start_run,
  // Open-drain error line
  input wire logic fault_line_in,
  output logic fault_line_out,
  output logic fault_line_oe,
  // Status
  output logic [2:0] state_out
);
  import lfm_pkg::*;

  initial
  begin
    if (EN_OFF_COUNT < 2 || SUPPLY_LOCKOUT_COUNT < 2 || MASK_COUNT < 1 || LEDS < 1)
      $error("lfm_fault_manager parameters out of range");
    if (IN_TRIP_CYC < 3)
      $error("lfm_fault_manager clock too slow for input trip time");
  end

  localparam int unsigned NS = 5 + LEDS;
  localparam int unsigned MW = $clog2(MASK_COUNT + 1);

  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  logic en_s, rise_s, fall_s, plim_s, slim_s, itrip_s;
  logic [LEDS-1:0] led_short_s;
  logic en_off_long, supply_lockout_filtered;
  logic supply_ok_reg, shutdown_reg, en_prev_reg;
  logic slim_latch_reg, itrip_latch_reg, led_short_now;
  logic truncate_reg, first_high_reg;
  logic [MW-1:0] mask_cnt_reg;
  lfm_state_t state_reg, state_next;
  logic latch_any, clear_latches, en_rise, mask_active;

  // Fault line readback unused: this variant drives only
  assign raw_in = {led_pin_short, input_trip_threshold,
                   secondary_limit_threshold, primary_switch_limit,
                   supply_below_falling, supply_above_rising} ^
                  {NS{1'b0}};

  lfm_sync #(
    .WIDTH(NS)
  ) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .din(raw_in),
    .dout(syn)
  );

  logic en_sync;
  lfm_sync #(
    .WIDTH(1)
  ) u_sync_en (
    .clock(clock),
    .arst_n(arst_n),
    .din(en_dim_pin),
    .dout(en_sync)
  );

  assign en_s = en_sync;
  assign rise_s = syn[0];
  assign fall_s = syn[1];
  assign plim_s = syn[2];
  // Secondary comparator trips near 1.4x primary level
  assign slim_s = syn[3];
  // Input comparator trips at the 98 mV sense level
  assign itrip_s = syn[4];
  assign led_short_s = syn[NS-1:5];

  lfm_timer #(
    .COUNT(EN_OFF_COUNT)
  ) u_en_off (
    .clock(clock),
    .arst_n(arst_n),
    .cond(!en_s),
    .expired(en_off_long)
  );

  lfm_timer #(
    .COUNT(SUPPLY_LOCKOUT_COUNT)
  ) u_supply_lockout (
    .clock(clock),
    .arst_n(arst_n),
    .cond(fall_s),
    .expired(supply_lockout_filtered)
  );

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      supply_ok_reg <= 1'b0;
    else if (supply_lockout_filtered)
      supply_ok_reg <= 1'b0;
    else if (rise_s)
      supply_ok_reg <= 1'b1;
  end

  // Shutdown after long low, left on next high
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      shutdown_reg <= 1'b1;
    else if (en_off_long)
      shutdown_reg <= 1'b1;
    else if (en_s)
      shutdown_reg <= 1'b0;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      en_prev_reg <= 1'b0;
    else
      en_prev_reg <= en_s;
  end

  assign en_rise = en_s && !en_prev_reg;
  // Lockout clears latches; only after the long low
  assign clear_latches = !supply_ok_reg || (shutdown_reg && en_rise);

  // Secondary limit latch, set wins over clear
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      slim_latch_reg <= 1'b0;
    else if (slim_s && supply_ok_reg)
      slim_latch_reg <= 1'b1;
    else if (clear_latches)
      slim_latch_reg <= 1'b0;
  end

  // Input overcurrent latch, active even in startup
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      itrip_latch_reg <= 1'b0;
    else if (itrip_s && supply_ok_reg)
      itrip_latch_reg <= 1'b1;
    else if (clear_latches)
      itrip_latch_reg <= 1'b0;
  end

  assign latch_any = slim_latch_reg || itrip_latch_reg;

  // Truncate on-time until next cycle begins
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      truncate_reg <= 1'b0;
    else if (plim_s)
      truncate_reg <= 1'b1;
    else if (cycle_start)
      truncate_reg <= 1'b0;
  end

  // First dimming high until soft start begins
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      first_high_reg <= 1'b1;
    else if (state_reg == LFM_OFF)
      first_high_reg <= 1'b1;
    else if (state_reg == LFM_SHORT_CHK && !(|led_short_s))
      first_high_reg <= 1'b0;
  end

  // Startup mask window, holds soft start before the move to run
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      mask_cnt_reg <= '0;
    else if (state_reg != LFM_SOFT)
      mask_cnt_reg <= '0;
    else if (mask_cnt_reg != MW'(MASK_COUNT))
      mask_cnt_reg <= mask_cnt_reg + MW'(1);
  end
  assign mask_active = (state_reg == LFM_SOFT) &&
                       (mask_cnt_reg != MW'(MASK_COUNT));

  // Short flag follows next state
  // Taken from the next state so the flag drops with the move to soft start
  assign led_short_now = first_high_reg && (state_next == LFM_SHORT_CHK) &&
                         (|led_short_s);

  // Sequencer reacting to every monitored input except the primary limit
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      LFM_OFF:
        if (supply_ok_reg && !shutdown_reg && en_s && !latch_any)
          state_next = LFM_SHORT_CHK;
      LFM_SHORT_CHK:
        if (!(|led_short_s))
          state_next = LFM_SOFT;
      LFM_SOFT:
        if (!mask_active)
          state_next = LFM_RUN;
      LFM_RUN:
        state_next = LFM_RUN;
      LFM_LATCHED:
        if (!latch_any)
          state_next = LFM_OFF;
      default:
        state_next = LFM_OFF;
    endcase
    if (latch_any)
      state_next = LFM_LATCHED;
    else if (!supply_ok_reg || shutdown_reg)
      state_next = LFM_OFF;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= LFM_OFF;
    else
      state_reg <= state_next;
  end

  // Gate drive removed within a few clocks of the trip
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      disconnect_gate_en <= 1'b0;
    else
      disconnect_gate_en <= !(itrip_s || slim_s) && !latch_any &&
                            (state_next != LFM_OFF) &&
                            (state_next != LFM_LATCHED);
  end

  // Sinks and boost held off during the short check
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      sinks_en <= 1'b0;
    else
      sinks_en <= !(itrip_s || slim_s) &&
                  ((state_next == LFM_SOFT) || (state_next == LFM_RUN));
  end

  // Boost blanked only for the truncated cycle
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      boost_gate_en <= 1'b0;
    else
      boost_gate_en <= !(itrip_s || slim_s || plim_s) &&
                       !(truncate_reg && !cycle_start) &&
                       ((state_next == LFM_SOFT) || (state_next == LFM_RUN));
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      soft_start_run <= 1'b0;
    else
      soft_start_run <= (state_next == LFM_SOFT);
  end

  // Open-drain error line, only ever pulls low
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      fault_line_oe <= 1'b0;
    else
      fault_line_oe <= latch_any || led_short_now ||
                       (slim_s && supply_ok_reg) ||
                       (itrip_s && supply_ok_reg);
  end
  assign fault_line_out = 1'b0;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      state_out <= 3'h0;
    else
      state_out <= state_next;
  end

  logic unused_fault_in;
  assign unused_fault_in = fault_line_in ^ first_high_reg;
endmodule : lfm_fault_manager

// ==== lfm_fault_manager_props.sv ====
// Port assertions for the fault manager
`timescale 1ns/10ps
module lfm_fault_manager_props #(
  parameter int unsigned EN_OFF_COUNT = 20,
  parameter int unsigned SUPPLY_LOCKOUT_COUNT = 8,
  parameter int unsigned LEDS = 6
) (
  // Clock and reset
  input logic clock,
  input logic arst_n,
  // Inputs
  input logic en_dim_pin,
  input logic supply_above_rising,
  input logic supply_below_falling,
  input logic primary_switch_limit,
  input logic secondary_limit_threshold,
  input logic input_trip_threshold,
  input logic [LEDS-1:0] led_pin_short,
  input logic cycle_start,
  input logic fault_line_in,
  // Outputs
  input logic boost_gate_en,
  input logic disconnect_gate_en,
  input logic sinks_en,
  input logic soft_start_run,
  input logic fault_line_out,
  input logic fault_line_oe,
  input logic [2:0] state_out
);
  int low_cnt;
  int uv_cnt;
  logic clear_ok;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      low_cnt <= 0;
    else
      low_cnt <= en_dim_pin ? 0 : low_cnt + 1;
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      uv_cnt <= 0;
    else
      uv_cnt <= supply_below_falling ? uv_cnt + 1 : 0;
  // Sticky: a legal clear was seen while latched
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      clear_ok <= 1'b0;
    else
      clear_ok <= state_out == 3'h4 && (clear_ok ||
        low_cnt >= EN_OFF_COUNT || uv_cnt >= SUPPLY_LOCKOUT_COUNT);
  property p_sec;
    $rose(secondary_limit_threshold) && state_out == 3'h3 |-> ##[1:3]
      (!boost_gate_en && !disconnect_gate_en && !sinks_en && fault_line_oe);
  endproperty
  a_sec: assert property (p_sec)
    else $error("secondary trip not latched off");
  property p_in;
    $rose(input_trip_threshold) && state_out == 3'h3 |-> ##3
      (!disconnect_gate_en && fault_line_oe) ##1 (state_out == 3'h4);
  endproperty
  a_in: assert property (p_in)
    else $error("input trip not latched off");
  property p_prim;
    $rose(primary_switch_limit) && state_out == 3'h3 && !fault_line_oe
      |-> ##[1:3] (!boost_gate_en && disconnect_gate_en && sinks_en);
  endproperty
  a_prim: assert property (p_prim)
    else $error("primary limit did not blank boost alone");
  property p_resume;
    (!primary_switch_limit)[*4] ##0 (cycle_start && state_out == 3'h3)
      |-> ##[1:3] boost_gate_en;
  endproperty
  a_resume: assert property (p_resume)
    else $error("boost did not resume after cycle start");
  property p_hold;
    state_out == 3'h4 && !clear_ok && low_cnt < EN_OFF_COUNT &&
      uv_cnt < SUPPLY_LOCKOUT_COUNT |=> state_out == 3'h4;
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch cleared early");
  property p_short;
    (state_out == 3'h1 && (|led_pin_short))[*4] |=>
      (state_out == 3'h1 && fault_line_oe && !sinks_en && !boost_gate_en);
  endproperty
  a_short: assert property (p_short)
    else $error("pin short did not hold startup");
  property p_soft;
    state_out == 3'h2 |-> soft_start_run && !fault_line_oe;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft start flag wrong");
  property p_od;
    !fault_line_out;
  endproperty
  a_od: assert property (p_od)
    else $error("error line driven high");
  property p_order;
    $rose(state_out == 3'h3) |-> $past(state_out) == 3'h2;
  endproperty
  a_order: assert property (p_order)
    else $error("run entered without soft start");
endmodule : lfm_fault_manager_props
bind lfm_fault_manager lfm_fault_manager_props #(.EN_OFF_COUNT(EN_OFF_COUNT),
  .SUPPLY_LOCKOUT_COUNT(SUPPLY_LOCKOUT_COUNT), .LEDS(LEDS)) i_props (.clock, .arst_n,
  .en_dim_pin, .supply_above_rising, .supply_below_falling,
  .primary_switch_limit, .secondary_limit_threshold, .input_trip_threshold,
  .led_pin_short, .cycle_start, .fault_line_in, .boost_gate_en,
  .disconnect_gate_en, .sinks_en, .soft_start_run, .fault_line_out,
  .fault_line_oe, .state_out);

// ==== lfm_ctrl_model.sv ====
// System controller model: enable pin and pulled-up error line
`timescale 1ns/10ps
module lfm_ctrl_model (
  // Clock
  input logic clock,
  // Bench request
  input logic en_req,
  // Device side
  input logic fault_oe,
  input logic fault_out,
  output logic en_dim_pin,
  output logic fault_wire
);
  always @(negedge clock)
    en_dim_pin <= en_req;
  assign fault_wire = fault_oe ? fault_out : 1'b1;
endmodule : lfm_ctrl_model

// ==== lfm_fault_manager_bench.sv ====
// Self-checking bench for the fault manager
`timescale 1ns/10ps
module lfm_fault_manager_bench;
  import lfm_pkg::*;
  logic clock = 1'b0, arst_n = 1'b0, en_req = 1'b0, en_dim_pin, fault_wire;
  logic supply_above_rising = 1'b0, supply_below_falling = 1'b0;
  logic primary_switch_limit = 1'b0, secondary_limit_threshold = 1'b0;
  logic input_trip_threshold = 1'b0, cycle_start = 1'b0;
  logic [5:0] led_pin_short = 6'h00;
  logic boost_gate_en, disconnect_gate_en, sinks_en, soft_start_run;
  logic fault_line_out, fault_line_oe;
  logic [2:0] state_out;
  logic [31:0] r;
  int seed = 32'h554b;
  int fails = 0;
  int checks_done = 0;
  int order[$] = '{1, 2, 3};
  always #25 clock = ~clock;
  lfm_fault_manager #(.EN_OFF_COUNT(20), .SUPPLY_LOCKOUT_COUNT(8), .MASK_COUNT(4)) i_dut
    (.clock, .arst_n, .en_dim_pin, .supply_above_rising,
    .supply_below_falling, .primary_switch_limit, .secondary_limit_threshold,
    .input_trip_threshold, .led_pin_short, .cycle_start, .boost_gate_en,
    .disconnect_gate_en, .sinks_en, .soft_start_run,
    .fault_line_in(fault_wire), .fault_line_out, .fault_line_oe, .state_out);
  lfm_ctrl_model i_ctrl (.clock, .en_req, .fault_oe(fault_line_oe),
    .fault_out(fault_line_out), .en_dim_pin, .fault_wire);
  task automatic close_out;
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(string nm, logic [2:0] seen, logic [2:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic cmp_all(int st, bit oe);
    chk("state", state_out, 3'(st));
    chk("disconnect", {2'h0, disconnect_gate_en}, {2'h0, st > 0 && st < 4});
    chk("sinks_boost", {1'b0, sinks_en, boost_gate_en},
      (st == 2 || st == 3) ? 3'h3 : 3'h0);
    chk("fault", {2'h0, fault_wire}, {2'h0, !oe});
  endtask : cmp_all
  task automatic wait_st(int st);
    int n = 0;
    while (state_out !== 3'(st) && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    if (state_out !== 3'(st))
    begin
      fails++;
      close_out();
    end
  endtask : wait_st
  // Startup walks short check, soft start, run in that order
  task automatic start_up;
    foreach (order[i])
    begin
      wait_st(order[i]);
      if (order[i] == 2)
        chk("soft", {2'h0, soft_start_run}, 3'h1);
    end
    cmp_all(3, 0);
  endtask : start_up
  task automatic en_low(int n);
    en_req <= 1'b0;
    repeat (n) @(negedge clock);
    en_req <= 1'b1;
  endtask : en_low
  initial
  begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    cmp_all(0, 0);
    r = $random(seed);
    led_pin_short <= r[5:0] | 6'h01;
    supply_above_rising <= 1'b1;
    en_req <= 1'b1;
    wait_st(1);
    repeat (6) @(negedge clock);
    cmp_all(1, 1);
    led_pin_short <= 6'h00;
    start_up();
    primary_switch_limit <= 1'b1;
    @(negedge clock);
    primary_switch_limit <= 1'b0;
    repeat (3) @(negedge clock);
    chk("stage", {boost_gate_en, disconnect_gate_en, sinks_en}, 3'h3);
    chk("fault", {2'h0, fault_wire}, 3'h1);
    cycle_start <= 1'b1;
    @(negedge clock);
    cycle_start <= 1'b0;
    repeat (3) @(negedge clock);
    cmp_all(3, 0);
    for (int k = 0; k < 2; k++)
    begin
      secondary_limit_threshold <= (k == 0);
      input_trip_threshold <= (k == 1);
      // Gates drop on the third edge, latched state shows on the fourth
      repeat (4) @(negedge clock);
      cmp_all(4, 1);
      secondary_limit_threshold <= 1'b0;
      input_trip_threshold <= 1'b0;
      en_low(10);
      repeat (8) @(negedge clock);
      cmp_all(4, 1);
      en_low(26);
      start_up();
    end
    input_trip_threshold <= 1'b1;
    @(negedge clock);
    input_trip_threshold <= 1'b0;
    supply_below_falling <= 1'b1;
    repeat (4) @(negedge clock);
    supply_below_falling <= 1'b0;
    repeat (8) @(negedge clock);
    cmp_all(4, 1);
    supply_above_rising <= 1'b0;
    supply_below_falling <= 1'b1;
    repeat (14) @(negedge clock);
    cmp_all(0, 0);
    close_out();
  end
endmodule : lfm_fault_manager_bench
